// ==== hw/usb_host_ep_attr_pkg.sv ====
// Package for the host-mode endpoint attribute block.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package usb_host_ep_attr_pkg;

    // Register byte offsets, one aligned word per register.
    localparam logic [7:0] OFS_RX_BYTE_COUNT = 8'h00;
    localparam logic [7:0] OFS_EP0_SPEED = 8'h04;
    localparam logic [7:0] OFS_TX_TYPE = 8'h08;
    localparam logic [7:0] OFS_EP0_NAK = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_CONTROL = 8'h18;

    localparam int COUNT_W = 13;
    localparam int SPEED_LSB = 6;
    localparam int PROTOCOL_LSB = 4;
    localparam int EPNUM_LSB = 0;
    localparam int NAK_W = 5;

    localparam logic [1:0] SPEED_RESET = 2'h1;
    localparam logic [1:0] PROTOCOL_RESET = 2'h0;
    localparam logic [3:0] EPNUM_RESET = 4'h0;
    localparam logic [4:0] NAK_RESET = 5'h00;
    localparam logic [4:0] NAK_MIN_VALID = 5'h02;
    localparam logic [4:0] NAK_MAX_VALID = 5'h10;

    // Interrupt status and mask bit positions.
    localparam int IRQ_PKT_READY = 0;
    localparam int IRQ_EP0_HALT = 1;
    localparam int IRQ_W = 2;

    // Control register bit positions.
    localparam int CTL_PKT_DONE = 0;
    localparam int CTL_EP0_RESUME = 1;

    typedef enum logic [1:0] {
        SPEED_ILLEGAL = 2'h0,
        SPEED_HIGH = 2'h1,
        SPEED_FULL = 2'h2,
        SPEED_LOW = 2'h3
    } speed_e;

    typedef enum logic [1:0] {
        PROTOCOL_CONTROL = 2'h0,
        PROTOCOL_ISOCHRONOUS = 2'h1,
        PROTOCOL_BULK = 2'h2,
        PROTOCOL_INTERRUPT = 2'h3
    } protocol_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_COUNTING = 3'b010,
        ST_HALTED = 3'b100
    } nak_state_e;

    // Transmit endpoint attributes as the link logic sees them.
    typedef struct packed {
        speed_e speed;
        protocol_e protocol;
        logic [3:0] endpoint;
    } tx_attr_s;

    // Endpoint 0 handshake report from the link logic, one per transaction.
    typedef struct packed {
        logic valid;
        logic nak;
    } ep0_hs_s;

endpackage : usb_host_ep_attr_pkg

// ==== hw/nak_frame_counter.sv ====
// Counts consecutive NAK-answered frames on endpoint 0 and flags a timeout.
// Assumes one-cycle frame and handshake pulses on i_clk.
`timescale 1ns/1ps
module nak_frame_counter
    import usb_host_ep_attr_pkg::*;
(
    input wire logic i_clk, // System clock.
    input wire logic i_sys_rst, // Synchronous reset, active high.
    input wire logic [NAK_W-1:0] i_limit, // Programmed limit m.
    input wire logic i_frame_tick, // Start of frame or microframe.
    input wire ep0_hs_s i_hs, // Endpoint 0 handshake report.
    input wire logic i_restart, // Drops the count, e.g. on resume.
    output logic o_expired // Pulse when the limit is exceeded.
);
    logic [16:0] count_r, count_nxt;
    logic nak_seen_r, nak_seen_nxt;
    logic expired_r, expired_nxt;
    logic [16:0] span;
    logic enabled;

    // Span is 2^(m-1) frames; values above 16 clamp to 16.
    always_comb begin
        enabled = (i_limit >= NAK_MIN_VALID);
        if (i_limit > NAK_MAX_VALID) begin
            span = 17'h08000;
        end else if (enabled) begin
            span = 17'h00001 << (i_limit - 5'h01);
        end else begin
            span = 17'h00000;
        end
    end

    always_comb begin
        count_nxt = count_r;
        nak_seen_nxt = nak_seen_r;
        expired_nxt = 1'b0;
        if (i_restart || !enabled) begin
            count_nxt = 17'h00000;
            nak_seen_nxt = 1'b0;
        end else begin
            if (i_hs.valid && !i_hs.nak) begin
                count_nxt = 17'h00000;
                nak_seen_nxt = 1'b0;
            end else if (i_hs.valid && i_hs.nak) begin
                nak_seen_nxt = 1'b1;
            end
            // A frame is counted once it closes with only NAKs inside it.
            if (i_frame_tick && nak_seen_r && !(i_hs.valid && !i_hs.nak)) begin
                count_nxt = count_r + 17'h00001;
                nak_seen_nxt = 1'b0;
                if (count_r + 17'h00001 > span) begin
                    expired_nxt = 1'b1;
                    count_nxt = 17'h00000;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            count_r <= 17'h00000;
            nak_seen_r <= 1'b0;
            expired_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            nak_seen_r <= nak_seen_nxt;
            expired_r <= expired_nxt;
        end
    end

    assign o_expired = expired_r;

endmodule : nak_frame_counter

// ==== hw/usb_host_endpoint_attributes.sv ====
// Host-mode endpoint attributes: receive byte count, target speed and
// transmit type registers, and the endpoint 0 NAK timeout with halt.
// Assumes an AHB-Lite master on i_clk and link logic on the same clock.
//
// What this block does
// - Read-only 13-bit received byte count, upper register bits read zero.
// - Count follows FIFO contents; valid only while packet-ready is set.
// - Endpoint 0 and transmit type registers hold target speed in bits 7-6.
// - Transmit type bits 5-4 select control, isochronous, bulk or interrupt.
// - Transmit type bits 3-0 give the target endpoint number used on the bus.
// - NAK limit m in bits 4-0, valid 2 to 16, span 2^(m-1) frames.
// - Halt endpoint 0 when NAKs persist longer than the programmed span.
// - A NAK limit of zero or one disables the timeout entirely.
// - Packet-ready rises when a packet lands in the FIFO; software clears it.
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module usb_host_endpoint_attributes
    import usb_host_ep_attr_pkg::*;
#(
    parameter int COUNT_WIDTH = COUNT_W
) (
    input wire logic i_clk, // System clock, 200 MHz.
    input wire logic i_sys_rst, // Synchronous reset, active high.
    input wire logic i_hsel, // AHB slave select.
    input wire logic [31:0] i_haddr, // AHB address.
    input wire logic [1:0] i_htrans, // AHB transfer type.
    input wire logic i_hwrite, // AHB write.
    input wire logic [2:0] i_hsize, // AHB size.
    input wire logic [31:0] i_hwdata, // AHB write data.
    input wire logic i_hready, // AHB bus ready.
    output logic [31:0] o_hrdata, // AHB read data.
    output logic o_hreadyout, // AHB slave ready.
    output logic o_hresp, // AHB response, always OKAY.
    input wire logic [COUNT_WIDTH-1:0] i_fifo_bytes, // Live receive FIFO fill.
    input wire logic i_pkt_received, // Pulse: packet stored in the FIFO.
    input wire logic i_frame_tick, // Pulse: frame or microframe start.
    input wire ep0_hs_s i_ep0_hs, // Endpoint 0 handshake report.
    output tx_attr_s o_tx_attr, // Transmit endpoint attributes.
    output speed_e o_ep0_speed, // Endpoint 0 target speed.
    output logic o_receive_packet_ready, // Receive packet-ready flag.
    output logic o_ep0_halted, // Endpoint 0 halted by NAK timeout.
    output logic o_irq // Level interrupt.
);
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    // Bus address phase capture.
    logic wr_pend_r, wr_pend_nxt;
    logic [7:0] wr_addr_r, wr_addr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic access;

    // Software-visible state.
    speed_e ep0_speed_r, ep0_speed_nxt;
    tx_attr_s tx_attr_r, tx_attr_nxt;
    logic [NAK_W-1:0] nak_limit_r, nak_limit_nxt;
    logic pkt_ready_r, pkt_ready_nxt;
    logic [COUNT_WIDTH-1:0] count_r, count_nxt;
    logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
    logic [IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
    logic irq_r, irq_nxt;
    nak_state_e nak_st_r, nak_st_nxt;

    // Decoded write strobes.
    logic wr_ctl, wr_stat;
    logic clr_pkt, resume;
    logic expired;
    logic [IRQ_W-1:0] irq_events;

    nak_frame_counter u_nak_counter (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_limit(nak_limit_r),
        .i_frame_tick(i_frame_tick),
        .i_hs(i_ep0_hs),
        .i_restart(nak_st_r != ST_COUNTING),
        .o_expired(expired)
    );

    assign access = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ || i_htrans == HTRANS_SEQ);

    // Bus front end; zero wait states, reads answered in the data phase.
    always_comb begin
        wr_pend_nxt = 1'b0;
        wr_addr_nxt = wr_addr_r;
        rdata_nxt = rdata_r;
        if (access && i_hwrite) begin
            wr_pend_nxt = 1'b1;
            wr_addr_nxt = i_haddr[7:0];
        end
        if (access && !i_hwrite) begin
            case (i_haddr[7:0])
                OFS_RX_BYTE_COUNT: begin
                    rdata_nxt = {{(32-COUNT_WIDTH){1'b0}}, count_r};
                end
                OFS_EP0_SPEED: begin
                    rdata_nxt = {24'h000000, ep0_speed_r, 6'h00};
                end
                OFS_TX_TYPE: begin
                    rdata_nxt = {24'h000000, tx_attr_r};
                end
                OFS_EP0_NAK: begin
                    rdata_nxt = {27'h0000000, nak_limit_r};
                end
                OFS_IRQ_STATUS: begin
                    rdata_nxt = {{(32-IRQ_W){1'b0}}, irq_stat_r};
                end
                OFS_IRQ_MASK: begin
                    rdata_nxt = {{(32-IRQ_W){1'b0}}, irq_mask_r};
                end
                OFS_CONTROL: begin
                    rdata_nxt = {30'h00000000, nak_st_r == ST_HALTED, pkt_ready_r};
                end
                default: begin
                    rdata_nxt = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rdata_r <= 32'h00000000;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign wr_ctl = wr_pend_r && (wr_addr_r == OFS_CONTROL);
    assign wr_stat = wr_pend_r && (wr_addr_r == OFS_IRQ_STATUS);
    assign clr_pkt = wr_ctl && i_hwdata[CTL_PKT_DONE];
    assign resume = wr_ctl && i_hwdata[CTL_EP0_RESUME];

    // Configuration registers written in the data phase.
    always_comb begin
        ep0_speed_nxt = ep0_speed_r;
        tx_attr_nxt = tx_attr_r;
        nak_limit_nxt = nak_limit_r;
        irq_mask_nxt = irq_mask_r;
        if (wr_pend_r) begin
            case (wr_addr_r)
                OFS_EP0_SPEED: begin
                    ep0_speed_nxt = speed_e'(i_hwdata[SPEED_LSB+:2]);
                end
                OFS_TX_TYPE: begin
                    tx_attr_nxt.speed = speed_e'(i_hwdata[SPEED_LSB+:2]);
                    tx_attr_nxt.protocol = protocol_e'(i_hwdata[PROTOCOL_LSB+:2]);
                    tx_attr_nxt.endpoint = i_hwdata[EPNUM_LSB+:4];
                end
                OFS_EP0_NAK: begin
                    nak_limit_nxt = i_hwdata[NAK_W-1:0];
                end
                OFS_IRQ_MASK: begin
                    irq_mask_nxt = i_hwdata[IRQ_W-1:0];
                end
                default: begin
                    irq_mask_nxt = irq_mask_r;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ep0_speed_r <= speed_e'(SPEED_RESET);
            tx_attr_r <= '{speed: speed_e'(SPEED_RESET), protocol: protocol_e'(PROTOCOL_RESET),
                           endpoint: EPNUM_RESET};
            nak_limit_r <= NAK_RESET;
            irq_mask_r <= '0;
        end else begin
            ep0_speed_r <= ep0_speed_nxt;
            tx_attr_r <= tx_attr_nxt;
            nak_limit_r <= nak_limit_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // Packet-ready flag and the live count; a new packet beats a clear.
    always_comb begin
        pkt_ready_nxt = pkt_ready_r;
        if (clr_pkt) begin
            pkt_ready_nxt = 1'b0;
        end
        if (i_pkt_received) begin
            pkt_ready_nxt = 1'b1;
        end
        // The count is not frozen: it follows the FIFO as software drains it.
        count_nxt = i_fifo_bytes;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pkt_ready_r <= 1'b0;
            count_r <= '0;
        end else begin
            pkt_ready_r <= pkt_ready_nxt;
            count_r <= count_nxt;
        end
    end

    // Endpoint 0 NAK timeout state.
    always_comb begin
        nak_st_nxt = nak_st_r;
        case (nak_st_r)
            ST_IDLE: begin
                if (nak_limit_r >= NAK_MIN_VALID) begin
                    nak_st_nxt = ST_COUNTING;
                end
            end
            ST_COUNTING: begin
                if (nak_limit_r < NAK_MIN_VALID) begin
                    nak_st_nxt = ST_IDLE;
                end else if (expired) begin
                    nak_st_nxt = ST_HALTED;
                end
            end
            ST_HALTED: begin
                if (resume) begin
                    nak_st_nxt = ST_IDLE;
                end
            end
            default: begin
                nak_st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            nak_st_r <= ST_IDLE;
        end else begin
            nak_st_r <= nak_st_nxt;
        end
    end

    // Sticky interrupt status, write one to clear; a new event wins.
    always_comb begin
        irq_events = '0;
        irq_events[IRQ_PKT_READY] = i_pkt_received;
        irq_events[IRQ_EP0_HALT] = (nak_st_r == ST_COUNTING) && expired;
        irq_stat_nxt = irq_stat_r;
        if (wr_stat) begin
            irq_stat_nxt = irq_stat_r & ~i_hwdata[IRQ_W-1:0];
        end
        irq_stat_nxt = irq_stat_nxt | irq_events;
        irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            irq_stat_r <= '0;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign o_hrdata = rdata_r;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_tx_attr = tx_attr_r;
    assign o_ep0_speed = ep0_speed_r;
    assign o_receive_packet_ready = pkt_ready_r;
    // The one-hot halted bit is the state flop itself, so no decode sits on the pin.
    assign o_ep0_halted = nak_st_r[2];
    assign o_irq = irq_r;

endmodule : usb_host_endpoint_attributes

// ==== sim/usb_host_ep_attr_sva.sv ====
// Concurrent checks on the host endpoint attribute block.
// Sees only the block's ports; bound to it at the foot of this file.
`timescale 1ns/1ps
module usb_host_ep_attr_sva
    import usb_host_ep_attr_pkg::*;
#(
    parameter int COUNT_WIDTH = COUNT_W
) (
    input wire logic i_clk, // Clock.
    input wire logic i_sys_rst, // Reset.
    input wire logic i_hsel, // Select.
    input wire logic [31:0] i_haddr, // Address.
    input wire logic [1:0] i_htrans, // Transfer type.
    input wire logic i_hwrite, // Write.
    input wire logic i_hready, // Bus ready.
    input wire logic [31:0] o_hrdata, // Read data.
    input wire logic i_pkt_received, // Packet stored.
    input wire tx_attr_s o_tx_attr, // Transmit attributes.
    input wire speed_e o_ep0_speed, // Endpoint 0 speed.
    input wire logic o_receive_packet_ready, // Packet-ready flag.
    input wire logic o_ep0_halted // Halted flag.
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic acc;
    logic wr_tx;
    logic wr_sp;
    logic wr_ctl;
    assign acc = i_hsel && i_hready && i_htrans[1];
    assign wr_tx = acc && i_hwrite && i_haddr[7:0] == OFS_TX_TYPE;
    assign wr_sp = acc && i_hwrite && i_haddr[7:0] == OFS_EP0_SPEED;
    assign wr_ctl = acc && i_hwrite && i_haddr[7:0] == OFS_CONTROL;
    sequence s_rd(logic [7:0] a);
        acc && !i_hwrite && i_haddr[7:0] == a;
    endsequence
    property p_cnt; s_rd(OFS_RX_BYTE_COUNT) |=> o_hrdata[31:COUNT_WIDTH] == '0; endproperty
    property p_sprd; s_rd(OFS_EP0_SPEED) |=> o_hrdata[5:0] == 6'h00; endproperty
    property p_nakrd; s_rd(OFS_EP0_NAK) |=> o_hrdata[31:5] == '0; endproperty
    property p_tx; $changed(o_tx_attr) |-> $past(wr_tx, 2); endproperty
    property p_sp; $changed(o_ep0_speed) |-> $past(wr_sp, 2); endproperty
    property p_pkt; i_pkt_received |=> o_receive_packet_ready; endproperty
    property p_clr; $fell(o_receive_packet_ready) |-> $past(wr_ctl, 2); endproperty
    property p_res; $fell(o_ep0_halted) |-> $past(wr_ctl, 2); endproperty
    a_cnt: assert property (p_cnt) else $error("count upper bits set");
    a_sprd: assert property (p_sprd) else $error("speed reserved bits set");
    a_nakrd: assert property (p_nakrd) else $error("nak limit upper bits set");
    a_tx: assert property (p_tx) else $error("tx type changed unwritten");
    a_sp: assert property (p_sp) else $error("ep0 speed changed unwritten");
    a_pkt: assert property (p_pkt) else $error("packet-ready not set");
    a_clr: assert property (p_clr) else $error("packet-ready fell unasked");
    a_res: assert property (p_res) else $error("halt left unasked");
endmodule : usb_host_ep_attr_sva

bind usb_host_endpoint_attributes usb_host_ep_attr_sva #(.COUNT_WIDTH(COUNT_WIDTH)) u_sva (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
    .i_pkt_received(i_pkt_received), .o_tx_attr(o_tx_attr), .o_ep0_speed(o_ep0_speed),
    .o_receive_packet_ready(o_receive_packet_ready), .o_ep0_halted(o_ep0_halted)
);

// ==== sim/usb_target_model.sv ====
// Behavioural USB target: frame timebase, endpoint 0 answers, packets.
// Steered by the bench; runs on the block's clock.
`timescale 1ns/1ps
module usb_target_model
    import usb_host_ep_attr_pkg::*;
#(
    parameter int FRAME = 16
) (
    input wire logic i_clk, // Clock.
    input wire logic [1:0] i_mode, // 0 quiet, 1 NAK, 2 ACK, 3 alternate.
    input wire logic i_send, // Deliver one packet.
    input wire logic [COUNT_W-1:0] i_len, // Its length.
    output logic o_frame_tick, // Frame start.
    output ep0_hs_s o_hs, // Handshake report.
    output logic [COUNT_W-1:0] o_fifo_bytes, // FIFO fill.
    output logic o_pkt_received // Packet stored.
);
    int cyc = 0;
    logic odd = 1'b0;
    initial begin
        o_frame_tick = 1'b0;
        o_hs = '0;
        o_fifo_bytes = '0;
        o_pkt_received = 1'b0;
    end
    always @(posedge i_clk) begin
        cyc <= (cyc + 1) % FRAME;
        o_frame_tick <= (cyc == 0);
        o_hs.valid <= (cyc == 4) && (i_mode != 2'h0);
        // Outside a report the nak bit toggles so a stale value is never trusted.
        o_hs.nak <= (cyc == 4) ? (i_mode == 2'h1 || (i_mode == 2'h3 && odd)) : ~o_hs.nak;
        if (cyc == 4) begin
            odd <= ~odd;
        end
        o_fifo_bytes <= i_send ? i_len : o_fifo_bytes;
        o_pkt_received <= i_send;
    end
endmodule : usb_target_model

// ==== sim/usb_host_endpoint_attributes_tb.sv ====
// Self-checking bench for the host endpoint attribute block.
// Drives AHB-Lite as the only master; the target model feeds the link side.
`timescale 1ns/1ps
module usb_host_endpoint_attributes_tb;
    import usb_host_ep_attr_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_hsel = 1'b0;
    logic [31:0] i_haddr = '0;
    logic [1:0] i_htrans = 2'h0;
    logic i_hwrite = 1'b0;
    logic [2:0] i_hsize = 3'h2;
    logic [31:0] i_hwdata = '0;
    logic [31:0] o_hrdata;
    logic o_hreadyout;
    logic o_hresp;
    logic tick;
    logic pkt;
    logic [COUNT_W-1:0] fifo;
    ep0_hs_s hs;
    tx_attr_s o_tx_attr;
    speed_e o_ep0_speed;
    logic o_receive_packet_ready;
    logic o_ep0_halted;
    logic o_irq;
    logic [1:0] mode = 2'h0;
    logic send = 1'b0;
    logic [COUNT_W-1:0] len = '0;
    logic [31:0] rd;
    int fails = 0;
    int n_compared = 0;
    always #2.5 i_clk = ~i_clk;
    usb_host_endpoint_attributes dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp), .i_fifo_bytes(fifo), .i_pkt_received(pkt), .i_frame_tick(tick),
        .i_ep0_hs(hs), .o_tx_attr(o_tx_attr), .o_ep0_speed(o_ep0_speed),
        .o_receive_packet_ready(o_receive_packet_ready), .o_ep0_halted(o_ep0_halted),
        .o_irq(o_irq)
    );
    usb_target_model u_target (
        .i_clk(i_clk), .i_mode(mode), .i_send(send), .i_len(len), .o_frame_tick(tick),
        .o_hs(hs), .o_fifo_bytes(fifo), .o_pkt_received(pkt)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask : chk
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        i_hsel <= 1'b1;
        i_haddr <= {24'h000000, a};
        i_htrans <= 2'h2;
        i_hwrite <= w;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        rd = o_hrdata;
        chk({31'h0, o_hresp}, 32'h0);
    endtask : xfer
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    task automatic ticks(input int n);
        repeat (n) begin
            do @(posedge i_clk); while (tick !== 1'b1);
        end
    endtask : ticks
    task automatic t_reset;
        rdchk(OFS_RX_BYTE_COUNT, 32'h0);
        rdchk(OFS_EP0_SPEED, 32'h40);
        rdchk(OFS_TX_TYPE, 32'h40);
        rdchk(OFS_EP0_NAK, 32'h0);
        xfer(8'h1C, 1'b1, 32'hFFFFFFFF);
        rdchk(8'h1C, 32'h0);
    endtask : t_reset
    task automatic t_attr;
        logic [7:0] d;
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 4; p++) begin
                d = {s[1:0], p[1:0], s[1:0], p[1:0]};
                xfer(OFS_TX_TYPE, 1'b1, {24'hFFFFFF, d});
                rdchk(OFS_TX_TYPE, {24'h0, d});
                chk({24'h0, o_tx_attr}, {24'h0, d});
            end
        end
        xfer(OFS_EP0_SPEED, 1'b1, 32'hFFFFFFFF);
        rdchk(OFS_EP0_SPEED, 32'hC0);
        chk({30'h0, o_ep0_speed}, 32'h3);
    endtask : t_attr
    task automatic t_pkt(input logic [12:0] l, input logic masked);
        xfer(OFS_IRQ_MASK, 1'b1, {31'h0, !masked});
        send <= 1'b1;
        len <= l;
        @(posedge i_clk);
        send <= 1'b0;
        repeat (3) @(posedge i_clk);
        rdchk(OFS_RX_BYTE_COUNT, {19'h0, l});
        rdchk(OFS_IRQ_STATUS, 32'h1);
        chk({31'h0, o_irq}, {31'h0, !masked});
        xfer(OFS_CONTROL, 1'b1, 32'h1);
        xfer(OFS_IRQ_STATUS, 1'b1, 32'h1);
        rdchk(OFS_CONTROL, 32'h0);
        chk({31'h0, o_irq}, 32'h0);
    endtask : t_pkt
    task automatic t_nak;
        xfer(OFS_EP0_NAK, 1'b1, 32'hFF);
        rdchk(OFS_EP0_NAK, 32'h1F);
        for (int m = 0; m < 3; m++) begin
            xfer(OFS_EP0_NAK, 1'b1, m);
            mode <= (m == 2) ? 2'h3 : 2'h1;
            ticks(10);
            chk({31'h0, o_ep0_halted}, 32'h0);
        end
        xfer(OFS_IRQ_MASK, 1'b1, 32'h2);
        mode <= 2'h1;
        ticks(2);
        chk({31'h0, o_ep0_halted}, 32'h0);
        ticks(2);
        repeat (8) @(posedge i_clk);
        chk({31'h0, o_ep0_halted}, 32'h1);
        rdchk(OFS_IRQ_STATUS, 32'h2);
        chk({31'h0, o_irq}, 32'h1);
        mode <= 2'h0;
        xfer(OFS_CONTROL, 1'b1, 32'h2);
        xfer(OFS_IRQ_STATUS, 1'b1, 32'h2);
        rdchk(OFS_CONTROL, 32'h0);
        chk({31'h0, o_irq}, 32'h0);
    endtask : t_nak
    task automatic report_and_stop;
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (10000) @(posedge i_clk);
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        t_reset();
        t_attr();
        t_pkt(13'h1FFF, 1'b0);
        t_pkt(13'h0000, 1'b1);
        t_nak();
        report_and_stop();
    end
endmodule : usb_host_endpoint_attributes_tb
